// ---- core/bobpe_core.sv ----
// Ordering gate for the forwarding queues plus parity error status and reporting.
// Assumes queue owners issue only heads whose go bit is set and pulse done when finished.
`timescale 1ns/1ps
`default_nettype none
module bobpe_core
  import bobpe_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic cfg_dperr_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Ordering, index 0 downstream, 1 upstream
  input wire bobpe_pkg::bobpe_ord_in_t [1:0] ord_i,
  output logic [1:0][NCLS-1:0] go_o,
  // Parity events
  input wire bobpe_pkg::bobpe_perr_t perr_i,
  output logic serr_cycle_o,
  output logic hl_master_abort_o,
  // Read return path
  input wire bobpe_pkg::bobpe_rdata_t rd_i,
  input wire logic rd_take_i,
  input wire logic rd_discard_i,
  output bobpe_pkg::bobpe_rdata_t rd_o,
  output logic rd_valid_o
);
  import bobpe_pkg::*;

  logic [15:0] cmd;
  logic [15:0] bctl;
  logic [15:0] primary_status;
  logic [15:0] secondary_status;
  logic [7:0] error_command;
  logic [7:0] error_status;
  logic apb_wr;
  logic apb_rd;
  logic cfg_bad;
  logic cmd_per;
  logic system_error_enable;
  logic bctl_per;
  logic serr_req;
  logic [15:0] pri_set;
  logic [15:0] sec_set;
  logic [7:0] ers_set;
  logic [15:0] pri_clr;
  logic [15:0] sec_clr;
  logic [7:0] ers_clr;
  logic [31:0] next_rdata;
  logic next_err;

  // Bus access strobes
  assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pready_o && !pwrite_i;
  assign cfg_bad = apb_wr && cfg_dperr_i;
  assign cmd_per = cmd[CMD_PER_BIT];
  assign system_error_enable = cmd[CMD_SYSTEM_ERROR_ENABLE_BIT];
  assign bctl_per = bctl[BCTL_PER_BIT];

  // APB ready: one wait state, then answer
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i && penable_i && !pready_o;
  end

  // Read mux and unmapped decode
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr_i)
      ADDR_CMD: next_rdata = {16'h0000, cmd};
      ADDR_PRI_STS: next_rdata = {16'h0000, primary_status};
      ADDR_SECONDARY_STATUS: next_rdata = {16'h0000, secondary_status};
      ADDR_BCTL: next_rdata = {16'h0000, bctl};
      ADDR_ERR_CMD: next_rdata = {24'h00_0000, error_command};
      ADDR_ERR_STS: next_rdata = {24'h00_0000, error_status};
      default: next_err = 1'b1;
    endcase
  end

  // Read data and error answer
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      prdata_o <= apb_rd ? next_rdata : 32'h0000_0000;
      pslverr_o <= next_err;
    end
    else
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  // Plain control registers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cmd <= CMD_RST;
      bctl <= BCTL_RST;
      error_command <= ERR_RST;
    end
    else if (apb_wr)
    begin
      if (paddr_i == ADDR_CMD)
        cmd <= pwdata_i[15:0];
      if (paddr_i == ADDR_BCTL)
        bctl <= pwdata_i[15:0];
      if (paddr_i == ADDR_ERR_CMD)
        error_command <= pwdata_i[7:0];
    end
  end

  // Event to flag mapping
  always_comb
  begin
    pri_set = 16'h0000;
    sec_set = 16'h0000;
    ers_set = 8'h00;
    pri_set[STS_DPE_BIT] = perr_i.hl_addr_perr || perr_i.pci_addr_perr || cfg_bad
      || perr_i.up_rd_dperr;
    sec_set[STS_DPE_BIT] = perr_i.pci_addr_perr || perr_i.dn_rd_dperr;
    pri_set[STS_DPD_BIT] = perr_i.up_rd_dperr && cmd_per;
    sec_set[STS_DPD_BIT] = perr_i.dn_rd_dperr && bctl_per;
    pri_set[STS_SSE_BIT] = serr_req;
    ers_set[ERS_HL_APE_BIT] = perr_i.hl_addr_perr;
    ers_set[ERS_PCI_APE_BIT] = perr_i.pci_addr_perr;
    ers_set[ERS_DPE_BIT] = cfg_bad || perr_i.dn_rd_dperr || perr_i.up_rd_dperr;
  end

  assign serr_req = system_error_enable && cmd_per && (perr_i.hl_addr_perr || perr_i.pci_addr_perr
    || cfg_bad || perr_i.dn_rd_dperr || perr_i.up_rd_dperr);

  // Write-one-to-clear masks
  assign pri_clr = (apb_wr && paddr_i == ADDR_PRI_STS) ? pwdata_i[15:0] : 16'h0000;
  assign sec_clr = (apb_wr && paddr_i == ADDR_SECONDARY_STATUS) ? pwdata_i[15:0] : 16'h0000;
  assign ers_clr = (apb_wr && paddr_i == ADDR_ERR_STS) ? pwdata_i[7:0] : 8'h00;

  // Sticky status, set beats clear
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      primary_status <= STS_RST;
      secondary_status <= STS_RST;
      error_status <= ERR_RST;
    end
    else
    begin
      primary_status <= (primary_status & ~pri_clr) | pri_set;
      secondary_status <= (secondary_status & ~sec_clr) | sec_set;
      error_status <= (error_status & ~ers_clr) | ers_set;
    end
  end

  // Upstream reporting on the host link
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      serr_cycle_o <= 1'b0;
      hl_master_abort_o <= 1'b0;
    end
    else
    begin
      serr_cycle_o <= serr_req;
      hl_master_abort_o <= perr_i.hl_addr_perr;
    end
  end

  // Read return stage
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rd_o <= '0;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_o <= rd_take_i ? rd_i : '0;
      rd_valid_o <= rd_take_i && !rd_discard_i;
      // initiator parity error not consumed here
    end
  end

  // Ordering gate, one per direction
  genvar d;
  generate
    for (d = 0; d < 2; d++)
    begin : g_dir
      logic [SEQ_W-1:0] pw_enq;
      logic [SEQ_W-1:0] pw_done;
      logic [SEQ_W-1:0] cpl_enq;
      logic [SEQ_W-1:0] cpl_done;
      logic [NCLS-1:0] slot_v;
      logic [SEQ_W-1:0] snap_pw [NCLS];
      logic [SEQ_W-1:0] snap_cpl [NCLS];
      logic enq_ok;
      logic is_cpl_enq;
      logic is_cpl_done;
      logic pw_fire;
      logic cpl_fire;
      bobpe_cls_t ec;
      bobpe_cls_t dc;

      assign ec = ord_i[d].enq_cls;
      assign dc = ord_i[d].done_cls;
      assign is_cpl_enq = ec == CLS_DRC || ec == CLS_DWC;
      assign is_cpl_done = dc == CLS_DRC || dc == CLS_DWC;
      // Posted queue refuses beyond counter range; delayed slots hold one each
      assign enq_ok = ord_i[d].enq && ((ec == CLS_PW) ? (pw_enq - pw_done) != SEQ_MAX
        : !slot_v[ec]);
      // One posted or one completion retires per cycle at most
      assign pw_fire = ord_i[d].done && dc == CLS_PW && pw_enq != pw_done;
      assign cpl_fire = ord_i[d].done && is_cpl_done && slot_v[dc];

      // Sequence counters
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          pw_enq <= '0;
          pw_done <= '0;
          cpl_enq <= '0;
          cpl_done <= '0;
        end
        else
        begin
          if (enq_ok && ec == CLS_PW)
            pw_enq <= pw_enq + 1'b1;
          if (ord_i[d].done && dc == CLS_PW && pw_enq != pw_done)
            pw_done <= pw_done + 1'b1;
          if (enq_ok && is_cpl_enq)
            cpl_enq <= cpl_enq + 1'b1;
          if (ord_i[d].done && is_cpl_done && slot_v[dc])
            cpl_done <= cpl_done + 1'b1;
        end
      end

      // Delayed slots count older items still ahead, so later passers never hold them
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          slot_v <= '0;
          for (int k = 0; k < NCLS; k++)
          begin
            snap_pw[k] <= '0;
            snap_cpl[k] <= '0;
          end
        end
        else
        begin
          // Each posted or completion retirement moves waiting slots one step nearer the head
          for (int k = 0; k < NCLS; k++)
          begin
            if (pw_fire && snap_pw[k] != '0)
              snap_pw[k] <= snap_pw[k] - 1'b1;
            if (cpl_fire && snap_cpl[k] != '0)
              snap_cpl[k] <= snap_cpl[k] - 1'b1;
          end
          if (ord_i[d].done && dc != CLS_PW)
            slot_v[dc] <= 1'b0;
          if (enq_ok && ec != CLS_PW)
          begin
            slot_v[ec] <= 1'b1;
            snap_pw[ec] <= pw_enq - pw_done - SEQ_W'(pw_fire);
            snap_cpl[ec] <= cpl_enq - cpl_done - SEQ_W'(cpl_fire);
          end
        end
      end

      // Issue permissions per class head
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
          go_o[d] <= '0;
        else
        begin
          go_o[d][CLS_PW] <= pw_enq != pw_done;
          go_o[d][CLS_DRR] <= slot_v[CLS_DRR] && snap_pw[CLS_DRR] == '0
            && snap_cpl[CLS_DRR] == '0;
          go_o[d][CLS_DWR] <= slot_v[CLS_DWR] && snap_pw[CLS_DWR] == '0
            && snap_cpl[CLS_DWR] == '0;
          go_o[d][CLS_DRC] <= slot_v[CLS_DRC] && snap_pw[CLS_DRC] == '0;
          go_o[d][CLS_DWC] <= slot_v[CLS_DWC];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- core/bobpe_pkg.sv ----
// Shared constants and carrier types for the bridge ordering and parity core.
// Assumes a single 50 MHz clock and an APB register port with 32-bit data.
package bobpe_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_CMD = 10'h004;
  localparam logic [9:0] IDX_PRI_STS = 10'h006;
  localparam logic [9:0] IDX_SECONDARY_STATUS = 10'h01e;
  localparam logic [9:0] IDX_BCTL = 10'h03e;
  localparam logic [9:0] IDX_ERR_CMD = 10'h090;
  localparam logic [9:0] IDX_ERR_STS = 10'h092;
  localparam logic [11:0] ADDR_CMD = {IDX_CMD, 2'b00};
  localparam logic [11:0] ADDR_PRI_STS = {IDX_PRI_STS, 2'b00};
  localparam logic [11:0] ADDR_SECONDARY_STATUS = {IDX_SECONDARY_STATUS, 2'b00};
  localparam logic [11:0] ADDR_BCTL = {IDX_BCTL, 2'b00};
  localparam logic [11:0] ADDR_ERR_CMD = {IDX_ERR_CMD, 2'b00};
  localparam logic [11:0] ADDR_ERR_STS = {IDX_ERR_STS, 2'b00};
  // Command register fields
  localparam int CMD_PER_BIT = 6;
  localparam int CMD_SYSTEM_ERROR_ENABLE_BIT = 8;
  // Bridge control field
  localparam int BCTL_PER_BIT = 0;
  // Status register fields (primary and secondary alike)
  localparam int STS_DPD_BIT = 8;
  localparam int STS_SSE_BIT = 14;
  localparam int STS_DPE_BIT = 15;
  // Error status fields
  localparam int ERS_HL_APE_BIT = 0;
  localparam int ERS_PCI_APE_BIT = 1;
  localparam int ERS_DPE_BIT = 2;
  // Reset values
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] BCTL_RST = 16'h0000;
  localparam logic [15:0] STS_RST = 16'h0000;
  localparam logic [7:0] ERR_RST = 8'h00;
  // Ordering counters
  localparam int SEQ_W = 4;
  localparam logic [SEQ_W-1:0] SEQ_MAX = 4'hf;
  localparam int NCLS = 5;

  typedef enum logic [2:0] {
    CLS_PW,
    CLS_DRR,
    CLS_DWR,
    CLS_DRC,
    CLS_DWC
  } bobpe_cls_t;

  // Queue events of one direction
  typedef struct packed {
    logic enq;
    bobpe_cls_t enq_cls;
    logic done;
    bobpe_cls_t done_cls;
  } bobpe_ord_in_t;

  // Parity events seen on both buses
  typedef struct packed {
    logic hl_addr_perr;
    logic pci_addr_perr;
    logic dn_rd_dperr;
    logic up_rd_dperr;
  } bobpe_perr_t;

  // Read data with its parity, passed untouched
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] par;
    logic bad_par;
  } bobpe_rdata_t;
endpackage

// ---- tb/bobpe_far_model.sv ----
// Queue owner on the far side: enqueues items and finishes heads.
// Assumes the bench asks for one finish at a time and waits on busy.
`timescale 1ns/1ps
`default_nettype none
module bobpe_far_model
  import bobpe_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic enq_i,
  input wire logic fin_i,
  input wire logic dir_i,
  input wire bobpe_pkg::bobpe_cls_t cls_i,
  input wire logic [1:0][NCLS-1:0] go_i,
  output bobpe_pkg::bobpe_ord_in_t [1:0] ord_o,
  output logic busy_o
);
  logic pend;
  logic pdir;
  bobpe_cls_t pcls;
  assign busy_o = pend;
  always_ff @(posedge mclk_i)
  begin
    ord_o <= '0;
    if (srst_i)
      pend <= 1'b0;
    else if (pend && go_i[pdir][pcls])
    begin
      ord_o[pdir].done <= 1'b1;
      ord_o[pdir].done_cls <= pcls;
      pend <= 1'b0;
    end
    else if (fin_i)
    begin
      pend <= 1'b1;
      pdir <= dir_i;
      pcls <= cls_i;
    end
    if (enq_i && !srst_i)
    begin
      ord_o[dir_i].enq <= 1'b1;
      ord_o[dir_i].enq_cls <= cls_i;
    end
  end
endmodule
`default_nettype wire

// ---- tb/bobpe_monitor.sv ----
// Port checker for the ordering and parity core.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/1ps
`default_nettype none
module bobpe_monitor
  import bobpe_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic cfg_dperr_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire bobpe_pkg::bobpe_ord_in_t [1:0] ord_i,
  input wire logic [1:0][NCLS-1:0] go_o,
  input wire bobpe_pkg::bobpe_perr_t perr_i,
  input wire logic serr_cycle_o,
  input wire logic hl_master_abort_o,
  input wire bobpe_pkg::bobpe_rdata_t rd_i,
  input wire logic rd_take_i,
  input wire logic rd_discard_i,
  input wire bobpe_pkg::bobpe_rdata_t rd_o,
  input wire logic rd_valid_o
);
  logic cause;
  // Any event that may start a report cycle
  assign cause = (perr_i != '0) || (cfg_dperr_i && psel_i && pwrite_i && pready_o);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  AST_PREADY: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
    else $error("no answer after one wait state");
  AST_ABORT: assert property (perr_i.hl_addr_perr |=> hl_master_abort_o)
    else $error("master abort missing");
  AST_ABORT_CAUSE: assert property (hl_master_abort_o |-> $past(perr_i.hl_addr_perr))
    else $error("master abort without cause");
  AST_SERR_CAUSE: assert property (serr_cycle_o |-> $past(cause))
    else $error("report cycle without cause");
  AST_RD_PASS: assert property (rd_take_i && !rd_discard_i
    |=> rd_valid_o && rd_o == $past(rd_i))
    else $error("read word altered");
  AST_RD_DISC: assert property (rd_discard_i |=> !rd_valid_o)
    else $error("discarded word delivered");
  AST_RD_CAUSE: assert property (rd_valid_o |-> $past(rd_take_i))
    else $error("read word without take");
  AST_DRR_GO: assert property ($rose(go_o[0][CLS_DRR])
    |-> $past(ord_i[0].done, 2) || $past(ord_i[0].enq, 2))
    else $error("read request released without cause");
  AST_PW_PASS: assert property (ord_i[0].enq && ord_i[0].enq_cls == CLS_PW && !ord_i[0].done
    ##1 !ord_i[0].done |=> go_o[0][CLS_PW])
    else $error("posted write held back");
endmodule
bind bobpe_core bobpe_monitor mon_u (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .cfg_dperr_i(cfg_dperr_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .ord_i(ord_i), .go_o(go_o), .perr_i(perr_i), .serr_cycle_o(serr_cycle_o),
  .hl_master_abort_o(hl_master_abort_o), .rd_i(rd_i), .rd_take_i(rd_take_i),
  .rd_discard_i(rd_discard_i), .rd_o(rd_o), .rd_valid_o(rd_valid_o));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench: APB master, parity events, read path, queue ordering.
// Assumes the far model owns queue events and the monitor is bound.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bobpe_pkg::*;
  logic mclk_i = 0;
  logic srst_i = 1;
  logic psel = 0, pen = 0, pwr = 0, dp = 0, take = 0, disc = 0, enq = 0, fin = 0, dir = 0;
  logic [11:0] pa = '0;
  logic [31:0] pw = '0;
  logic [31:0] prdata;
  logic pready, pslverr, serr, mab, rdv, busy;
  logic [1:0][NCLS-1:0] go;
  bobpe_ord_in_t [1:0] ord;
  bobpe_perr_t pe = '0;
  bobpe_rdata_t rdi = '0;
  bobpe_rdata_t rdo;
  bobpe_cls_t cls = CLS_PW;
  logic [32:0] expq[$];
  int n_mismatch = 0, compares = 0, cyc = 0;
  logic [11:0] adr[6] = '{ADDR_CMD, ADDR_PRI_STS, ADDR_SECONDARY_STATUS, ADDR_BCTL, ADDR_ERR_CMD,
    ADDR_ERR_STS};
  logic [7:0] tbl[8] = '{8'h81, 8'h82, 8'hc3, 8'h9a, 8'h08, 8'h0c, 8'h11, 8'h18};
  always #10 mclk_i = ~mclk_i;
  bobpe_core dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw), .cfg_dperr_i(dp), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .ord_i(ord), .go_o(go), .perr_i(pe),
    .serr_cycle_o(serr), .hl_master_abort_o(mab), .rd_i(rdi), .rd_take_i(take),
    .rd_discard_i(disc), .rd_o(rdo), .rd_valid_o(rdv));
  bobpe_far_model far_u (.mclk_i(mclk_i), .srst_i(srst_i), .enq_i(enq), .fin_i(fin),
    .dir_i(dir), .cls_i(cls), .go_i(go), .ord_o(ord), .busy_o(busy));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge mclk_i);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pw <= d;
    dp <= e;
    @(posedge mclk_i);
    pen <= 1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
    dp <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    expq.push_back(x);
    apb(0, a, 0, 0);
  endtask
  task automatic clr;
    apb(1, ADDR_PRI_STS, 32'h0000_ffff, 0);
    apb(1, ADDR_SECONDARY_STATUS, 32'h0000_ffff, 0);
    apb(1, ADDR_ERR_STS, 32'h0000_00ff, 0);
  endtask
  task automatic ev(input bobpe_perr_t v, input logic [1:0] x);
    @(posedge mclk_i);
    pe <= v;
    @(posedge mclk_i);
    pe <= '0;
    #1 chk(33'({serr, mab}), 33'(x));
  endtask
  task automatic q(input logic f, input logic d, input bobpe_cls_t c);
    int i;
    @(posedge mclk_i);
    enq <= !f;
    fin <= f;
    dir <= d;
    cls <= c;
    @(posedge mclk_i);
    enq <= 0;
    fin <= 0;
    #1;
    for (i = 0; i < 50 && busy === 1'b1; i++) @(posedge mclk_i);
    repeat (3) @(posedge mclk_i);
    #1;
    chk(33'(busy), 33'h0);
  endtask
  // Timeout and read answer watcher
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
    if (psel && pen && !pwr && pready === 1'b1)
      chk({pslverr, prdata}, expq.pop_front());
  end
  initial
  begin
    logic [72:0] x;
    logic [31:0] r;
    bobpe_cls_t a, b;
    void'($urandom(32'h7af6));
    repeat (16) @(posedge mclk_i);
    srst_i <= 0;
    // Reset values, unmapped refusal, plain storage
    foreach (adr[i]) rd(adr[i], 33'h0);
    rd(12'h7fc, 33'h1_0000_0000);
    r = $urandom;
    apb(1, ADDR_ERR_CMD, r, 0);
    rd(ADDR_ERR_CMD, 33'(r[7:0]));
    apb(1, ADDR_ERR_CMD, ~r, 1);
    rd(ADDR_ERR_CMD, {25'h0, ~r[7:0]});
    rd(ADDR_PRI_STS, 33'h8000);
    clr();
    $display("test registers done");
    // Address and data parity events with enables off then on
    for (int e = 0; e < 2; e++)
    begin
      apb(1, ADDR_CMD, e ? 32'h0000_0140 : 32'h0, 0);
      apb(1, ADDR_BCTL, 32'(e), 0);
      ev(4'b1000, {e[0], 1'b1});
      rd(ADDR_PRI_STS, e ? 33'hc000 : 33'h8000);
      rd(ADDR_ERR_STS, 33'h1);
      clr();
      ev(4'b0100, {e[0], 1'b0});
      rd(ADDR_PRI_STS, e ? 33'hc000 : 33'h8000);
      rd(ADDR_SECONDARY_STATUS, 33'h8000);
      clr();
      ev(4'b0010, {e[0], 1'b0});
      rd(ADDR_SECONDARY_STATUS, e ? 33'h8100 : 33'h8000);
      rd(ADDR_ERR_STS, 33'h4);
      clr();
      ev(4'b0001, {e[0], 1'b0});
      rd(ADDR_PRI_STS, e ? 33'hc100 : 33'h8000);
      clr();
    end
    $display("test parity done");
    // Read words pass untouched; unread prefetch dropped
    // initiator error report has no pin on this core, so has nothing to act on
    for (int i = 0; i < 8; i++)
    begin
      x = {$urandom, $urandom, 9'($urandom)};
      @(posedge mclk_i);
      rdi <= x;
      take <= 1;
      disc <= (i % 3 == 2);
      @(posedge mclk_i);
      rdi <= ~x;
      take <= 0;
      disc <= 0;
      #1 chk(33'(rdv), 33'(i % 3 != 2));
      if (i % 3 != 2) chk(33'(rdo !== bobpe_rdata_t'(x)), 33'h0);
    end
    $display("test read path done");
    // Posted writes keep their order
    q(0, 0, CLS_PW);
    q(0, 0, CLS_PW);
    q(1, 0, CLS_PW);
    chk(33'(go[0][CLS_PW]), 33'h1);
    q(1, 0, CLS_PW);
    chk(33'(go[0][CLS_PW]), 33'h0);
    // Blocking and passing pairs from the table
    foreach (tbl[k])
    begin
      a = bobpe_cls_t'(tbl[k][5:3]);
      b = bobpe_cls_t'(tbl[k][2:0]);
      q(0, tbl[k][6], a);
      q(0, tbl[k][6], b);
      chk(33'(go[tbl[k][6]][b]), 33'(!tbl[k][7]));
      if (tbl[k][7])
      begin
        q(1, tbl[k][6], a);
        chk(33'(go[tbl[k][6]][b]), 33'h1);
        q(1, tbl[k][6], b);
      end
      else
      begin
        q(1, tbl[k][6], b);
        q(1, tbl[k][6], a);
      end
    end
    $display("test ordering done");
    results();
  end
endmodule
`default_nettype wire
